// File: rtl/mef_pkg.sv
// constants shared by the event-flag logic: register map, field layout, reset values
package mef_pkg;

	// number of monitor selectors and of user access channels
	localparam int unsigned MEF_NUM_CH = 2;
	localparam int unsigned MEF_DATA_W = 32;
	localparam int unsigned MEF_DEC_W = 8;
	localparam int unsigned MEF_PHY_W = 5;
	localparam int unsigned MEF_LINK_W = 32;

	// byte offsets of the register map
	localparam logic [7:0] MEF_OFS_LINK_RAW = 8'h00;
	localparam logic [7:0] MEF_OFS_LINK_MASKED = 8'h04;
	localparam logic [7:0] MEF_OFS_CMD_RAW = 8'h08;
	localparam logic [7:0] MEF_OFS_CMD_MASKED = 8'h0c;
	localparam logic [7:0] MEF_OFS_CMD_MASK_SET = 8'h10;
	localparam logic [7:0] MEF_OFS_CMD_MASK_CLR = 8'h14;
	localparam logic [7:0] MEF_OFS_SEL_BASE = 8'h18;
	localparam logic [7:0] MEF_SEL_STRIDE = 8'h04;
	localparam logic [7:0] MEF_OFS_LINK_STATE = 8'h20;

	// monitor selector layout: phy address in the low bits, enable above
	localparam int unsigned MEF_SEL_ADDR_LSB = 0;
	localparam int unsigned MEF_SEL_EN_BIT = 6;
	localparam int unsigned MEF_SEL_W = 7;

	// reset values
	localparam logic [MEF_DATA_W-1:0] MEF_FLAG_RST = 32'h0000_0000;
	localparam logic [MEF_LINK_W-1:0] MEF_LINK_RST = 32'h0000_0000;
	localparam logic [MEF_SEL_W-1:0] MEF_SEL_RST = 7'h00;
	localparam logic [MEF_DATA_W-1:0] MEF_RDATA_RST = 32'h0000_0000;

	// ahb-lite encodings
	localparam logic [2:0] MEF_HSIZE_WORD = 3'h2;
	localparam logic [1:0] MEF_HRESP_OKAY = 2'h0;

endpackage

// File: rtl/mef_flag_bank.sv
// sticky flag bank: hardware sets, software clears, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module mef_flag_bank #(
	parameter int unsigned W = 2
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flags_q
);

	logic [W-1:0] flags_d;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// a set in the cycle of a clear must not be lost
			assign flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
		end
	endgenerate

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= W'(mef_pkg::MEF_FLAG_RST);
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule
`default_nettype wire

// File: rtl/mef_ahb_slave.sv
// ahb-lite slave front end: writes with no wait state, reads with one
`timescale 1ns/1ps
`default_nettype none
module mef_ahb_slave (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data
);

	logic ph_valid_q;
	logic ph_write_q;
	logic ph_word_q;
	logic [7:0] ph_addr_q;
	logic rd_done_q;
	logic [31:0] hrdata_q;
	wire addr_take;
	wire rd_load;

	// nonseq or seq both start a transfer; idle and busy are ignored
	assign addr_take = hsel & htrans[1] & hready;
	// read data are registered, so a read waits one cycle to sample its word
	assign rd_load = ph_valid_q & ~ph_write_q & ~rd_done_q;
	assign hreadyout = ~rd_load;
	assign hresp = mef_pkg::MEF_HRESP_OKAY;
	assign hrdata = hrdata_q;
	// only whole-word writes change a register; narrower ones are dropped
	assign wr_en = ph_valid_q & ph_write_q & ph_word_q;
	assign wr_addr = ph_addr_q;
	assign wr_data = hwdata;
	assign rd_addr = ph_addr_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_word_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end else if (addr_take) begin
			ph_valid_q <= 1'b1;
			ph_write_q <= hwrite;
			ph_word_q <= (hsize == mef_pkg::MEF_HSIZE_WORD);
			ph_addr_q <= {haddr[7:2], 2'b00};
		end else if (hreadyout) begin
			ph_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_done_q <= 1'b0;
			hrdata_q <= mef_pkg::MEF_RDATA_RST;
		end else begin
			rd_done_q <= rd_load;
			if (rd_load) begin
				hrdata_q <= rd_data;
			end
		end
	end

endmodule
`default_nettype wire

// File: rtl/mef_top.sv
// event-flag logic of an mdio management controller with an ahb-lite register port
// What this block does
// - masked link flag needs change and enable
// - link flag bit n follows selector n
// - one clears masked link flag, zero ignored
// - raw command flag set on channel completion
// - command flag bit n follows channel n
// - one clears raw command flag, zero ignored
// - flags reset to zero, reserved bits zero
// - masked command flag is raw and mask
// - link bits refreshed per status read, ack
// - raw link flag set regardless of enable
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mef_top #(
	parameter int unsigned NCH = mef_pkg::MEF_NUM_CH
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic status_rd_done,
	input wire logic [4:0] status_rd_phy,
	input wire logic status_rd_ack,
	input wire logic status_rd_link,
	input wire logic [NCH-1:0] cmd_done,
	output logic [31:0] link_state,
	output logic link_irq,
	output logic cmd_irq,
	output logic irq
);

	localparam int unsigned DW = mef_pkg::MEF_DATA_W;
	localparam int unsigned SW = mef_pkg::MEF_SEL_W;
	localparam int unsigned PW = mef_pkg::MEF_PHY_W;
	localparam int unsigned LW = mef_pkg::MEF_LINK_W;

	// selector bits that hold something: the address field and the enable bit
	localparam logic [SW-1:0] SEL_KEEP =
		(SW'({PW{1'b1}}) << mef_pkg::MEF_SEL_ADDR_LSB) |
		(SW'(1) << mef_pkg::MEF_SEL_EN_BIT);

	// register port
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;

	// decoded write strobes
	wire wr_link_raw;
	wire wr_link_masked;
	wire wr_cmd_raw;
	wire wr_cmd_masked;
	wire wr_mask_set;
	wire wr_mask_clr;
	wire [NCH-1:0] wr_data_lo;

	// link state tracking
	logic [LW-1:0] link_state_q;
	logic [LW-1:0] link_state_d;
	wire [LW-1:0] phy_onehot;
	wire link_new_bit;
	wire link_old_bit;
	wire link_flip;

	// per-channel selector state and events
	logic [SW-1:0] sel_q [NCH];
	wire [NCH-1:0] sel_en;
	wire [NCH-1:0] link_evt;
	wire [NCH-1:0] link_evt_en;

	// flag banks
	wire [NCH-1:0] link_raw_clr;
	wire [NCH-1:0] link_masked_clr;
	wire [NCH-1:0] cmd_raw_clr;
	wire [NCH-1:0] mask_set;
	wire [NCH-1:0] mask_clr;
	logic [NCH-1:0] link_raw_q;
	logic [NCH-1:0] link_masked_q;
	logic [NCH-1:0] cmd_raw_q;
	logic [NCH-1:0] cmd_mask_q;
	wire [NCH-1:0] cmd_masked;

	// read path pieces, each padded to a full word
	wire [DW-NCH-1:0] pad_zero;
	wire [DW-1:0] rd_link_raw;
	wire [DW-1:0] rd_link_masked;
	wire [DW-1:0] rd_cmd_raw;
	wire [DW-1:0] rd_cmd_masked;
	wire [DW-1:0] rd_cmd_mask;
	wire [DW-1:0] rd_sel [NCH];
	wire [DW-1:0] rd_sel_any;
	wire [NCH-1:0] rd_sel_hit;

	// bus front end; only whole-word writes ever reach wr_en, so narrower ones change nothing
	mef_ahb_slave u_ahb (
		.mclk(mclk),
		.resetn(resetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// ---- write decode

	assign wr_link_raw = wr_en & (wr_addr == mef_pkg::MEF_OFS_LINK_RAW);
	assign wr_link_masked = wr_en & (wr_addr == mef_pkg::MEF_OFS_LINK_MASKED);
	assign wr_cmd_raw = wr_en & (wr_addr == mef_pkg::MEF_OFS_CMD_RAW);
	assign wr_cmd_masked = wr_en & (wr_addr == mef_pkg::MEF_OFS_CMD_MASKED);
	assign wr_mask_set = wr_en & (wr_addr == mef_pkg::MEF_OFS_CMD_MASK_SET);
	assign wr_mask_clr = wr_en & (wr_addr == mef_pkg::MEF_OFS_CMD_MASK_CLR);
	// upper write data bits have nothing behind them
	assign wr_data_lo = wr_data[NCH-1:0];

	// ---- link state bits

	assign link_new_bit = status_rd_ack & status_rd_link;
	assign phy_onehot = LW'(1) << status_rd_phy;
	assign link_old_bit = link_state_q[status_rd_phy];
	// only a bit that really moves is a change; a repeated read with the
	// same outcome raises nothing
	assign link_flip = status_rd_done & (link_new_bit != link_old_bit);
	assign link_state_d = status_rd_done ?
		((link_state_q & ~phy_onehot) | (link_new_bit ? phy_onehot : '0)) :
		link_state_q;
	// the word is read-only to software; a phy that never answers keeps its bit clear
	assign link_state = link_state_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link_state_q <= mef_pkg::MEF_LINK_RST;
		end else begin
			link_state_q <= link_state_d;
		end
	end

	// ---- monitor selectors

	// selectors reset to phy 0 with the link interrupt off
	genvar n;
	generate
		for (n = 0; n < NCH; n++) begin : g_ch
			wire [7:0] sel_ofs;
			wire sel_wr;
			wire [PW-1:0] sel_phy;
			wire [SW-1:0] sel_wdata;

			assign sel_ofs = mef_pkg::MEF_OFS_SEL_BASE + 8'(n * mef_pkg::MEF_SEL_STRIDE);
			assign sel_wr = wr_en & (wr_addr == sel_ofs);
			assign sel_phy = sel_q[n][mef_pkg::MEF_SEL_ADDR_LSB +: PW];
			assign sel_en[n] = sel_q[n][mef_pkg::MEF_SEL_EN_BIT];
			// a selector rewrite compares nothing, so it never raises an event by itself
			// the unused bit between address and enable must read back as zero
			assign sel_wdata = wr_data[SW-1:0] & SEL_KEEP;

			// event bit n from selector n
			assign link_evt[n] = link_flip & (status_rd_phy == sel_phy);
			assign link_evt_en[n] = link_evt[n] & sel_en[n];

			assign rd_sel_hit[n] = (rd_addr == sel_ofs);
			assign rd_sel[n] = rd_sel_hit[n] ? DW'(sel_q[n]) : '0;

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					sel_q[n] <= mef_pkg::MEF_SEL_RST;
				end else if (sel_wr) begin
					sel_q[n] <= sel_wdata;
				end
			end
		end
	endgenerate

	// ---- flags

	assign link_masked_clr = {NCH{wr_link_masked}} & wr_data_lo;
	// raw and masked link flags clear apart; one view never clears the other
	assign link_raw_clr = {NCH{wr_link_raw}} & wr_data_lo;
	// one clears command event
	// clearing through the masked view also clears the event underneath
	assign cmd_raw_clr = ({NCH{wr_cmd_raw}} | {NCH{wr_cmd_masked}}) & wr_data_lo;
	// the mask is written through two offsets, one setting and one clearing
	assign mask_set = {NCH{wr_mask_set}} & wr_data_lo;
	assign mask_clr = {NCH{wr_mask_clr}} & wr_data_lo;

	mef_flag_bank #(
		.W(NCH)
	) u_link_raw (
		.mclk(mclk),
		.resetn(resetn),
		.set(link_evt),
		.clr(link_raw_clr),
		.flags_q(link_raw_q)
	);

	mef_flag_bank #(
		.W(NCH)
	) u_link_masked (
		.mclk(mclk),
		.resetn(resetn),
		.set(link_evt_en),
		.clr(link_masked_clr),
		.flags_q(link_masked_q)
	);

	mef_flag_bank #(
		.W(NCH)
	) u_cmd_raw (
		.mclk(mclk),
		.resetn(resetn),
		.set(cmd_done),
		.clr(cmd_raw_clr),
		.flags_q(cmd_raw_q)
	);

	// set and clear sit at different addresses, so they never meet
	mef_flag_bank #(
		.W(NCH)
	) u_cmd_mask (
		.mclk(mclk),
		.resetn(resetn),
		.set(mask_set),
		.clr(mask_clr),
		.flags_q(cmd_mask_q)
	);

	assign cmd_masked = cmd_raw_q & cmd_mask_q;

	// ---- interrupts

	assign link_irq = |link_masked_q;
	// the masked command view is not stored, so a mask change shows at once
	assign cmd_irq = |cmd_masked;
	// one combined line for a system that wires a single interrupt
	assign irq = link_irq | cmd_irq;

	// ---- read mux

	// reserved bits read zero
	// only NCH bits per flag word exist; the rest is tied to zero
	assign pad_zero = '0;
	assign rd_link_raw = {pad_zero, link_raw_q};
	assign rd_link_masked = {pad_zero, link_masked_q};
	assign rd_cmd_raw = {pad_zero, cmd_raw_q};
	assign rd_cmd_masked = {pad_zero, cmd_masked};
	// both mask views read back the current mask
	assign rd_cmd_mask = {pad_zero, cmd_mask_q};

	// at most one selector offset can hit, so the reads are simply ored
	generate
		if (NCH == 1) begin : g_sel1
			assign rd_sel_any = rd_sel[0];
		end else begin : g_seln
			wire [DW-1:0] acc [NCH];
			assign acc[0] = rd_sel[0];
			for (n = 1; n < NCH; n++) begin : g_or
				assign acc[n] = acc[n-1] | rd_sel[n];
			end
			assign rd_sel_any = acc[NCH-1];
		end
	endgenerate

	// unmapped offsets read zero and still answer okay
	assign rd_data =
		(rd_addr == mef_pkg::MEF_OFS_LINK_RAW) ? rd_link_raw :
		(rd_addr == mef_pkg::MEF_OFS_LINK_MASKED) ? rd_link_masked :
		(rd_addr == mef_pkg::MEF_OFS_CMD_RAW) ? rd_cmd_raw :
		(rd_addr == mef_pkg::MEF_OFS_CMD_MASKED) ? rd_cmd_masked :
		(rd_addr == mef_pkg::MEF_OFS_CMD_MASK_SET) ? rd_cmd_mask :
		(rd_addr == mef_pkg::MEF_OFS_CMD_MASK_CLR) ? rd_cmd_mask :
		(rd_addr == mef_pkg::MEF_OFS_LINK_STATE) ? link_state_q :
		rd_sel_any;

endmodule
`default_nettype wire

// File: tb/mef_props.sv
// concurrent checks on the ports of the event-flag block
`timescale 1ns/1ps
`default_nettype none
module mef_props #(
	parameter int unsigned NCH = 2
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [1:0] hresp,
	input wire logic status_rd_done,
	input wire logic [4:0] status_rd_phy,
	input wire logic status_rd_ack,
	input wire logic status_rd_link,
	input wire logic [NCH-1:0] cmd_done,
	input wire logic [31:0] link_state,
	input wire logic link_irq,
	input wire logic cmd_irq,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic wr_ap = hsel & htrans[1] & hwrite & hready;
	wire logic rd_ap = hsel & htrans[1] & !hwrite & hready;
	a_irq_is_or: assert property (irq == (link_irq | cmd_irq))
		else $error("irq differs from or of sources");
	a_state_follows_read: assert property (
		status_rd_done |=> link_state[$past(status_rd_phy)] == $past(status_rd_ack & status_rd_link))
		else $error("link state bit not refreshed");
	a_state_holds: assert property (!status_rd_done |=> $stable(link_state))
		else $error("link state moved without a status read");
	a_link_rise_cause: assert property ($rose(link_irq) |-> $past(status_rd_done))
		else $error("link irq rose without an event");
	a_link_fall_cause: assert property ($fell(link_irq) |-> $past(wr_ap, 2))
		else $error("link irq fell without a write");
	a_cmd_rise_cause: assert property (
		$rose(cmd_irq) |-> $past(cmd_done) != 0 || $past(wr_ap, 2))
		else $error("cmd irq rose without cause");
	a_cmd_fall_cause: assert property ($fell(cmd_irq) |-> $past(wr_ap, 2))
		else $error("cmd irq fell without a write");
	a_read_wait: assert property (rd_ap |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 2'h0)
		else $error("response not okay");
	c_link_irq: cover property ($rose(link_irq));
	c_cmd_irq: cover property ($rose(cmd_irq));
	c_read: cover property (rd_ap ##2 hreadyout);
endmodule
`default_nettype wire

// File: tb/mef_phy_model.sv
// far-side model: phys finishing status reads and user commands
`timescale 1ns/1ps
`default_nettype none
module mef_phy_model (
	input wire logic mclk,
	output logic rd_done,
	output logic [4:0] rd_phy,
	output logic rd_ack,
	output logic rd_link,
	output logic [1:0] cmd_done
);
	initial begin
		rd_done = 1'b0;
		rd_phy = 5'h00;
		rd_ack = 1'b0;
		rd_link = 1'b0;
		cmd_done = 2'h0;
	end
	// result valid only with the pulse
	task automatic status_read(input logic [4:0] p, input logic a, input logic l);
		@(posedge mclk);
		rd_done <= 1'b1;
		rd_phy <= p;
		rd_ack <= a;
		rd_link <= l;
		@(posedge mclk);
		// released lines show the inverse so a stale value cannot pass
		rd_done <= 1'b0;
		rd_phy <= ~p;
		rd_ack <= ~a;
		rd_link <= ~l;
	endtask
	task automatic finish(input int ch);
		@(posedge mclk);
		cmd_done[ch] <= 1'b1;
		@(posedge mclk);
		cmd_done <= 2'h0;
	endtask
endmodule
`default_nettype wire

// File: tb/mef_top_bench.sv
// self-checking bench for the event-flag block
`timescale 1ns/1ps
`default_nettype none
module mef_top_bench;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	wire logic hreadyout, status_rd_done, status_rd_ack, status_rd_link, link_irq, cmd_irq, irq;
	wire logic [1:0] hresp;
	wire logic [1:0] cmd_done;
	wire logic [4:0] status_rd_phy;
	wire logic [31:0] hrdata;
	wire logic [31:0] link_state;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	always #5 mclk = ~mclk;
	mef_top DUT (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .status_rd_done, .status_rd_phy,
		.status_rd_ack, .status_rd_link, .cmd_done, .link_state, .link_irq, .cmd_irq, .irq);
	mef_phy_model phy (.mclk, .rd_done(status_rd_done), .rd_phy(status_rd_phy),
		.rd_ack(status_rd_ack), .rd_link(status_rd_link), .cmd_done);
	task automatic print_verdict();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// a hung handshake ends here
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one single transfer; hready is sampled at each edge, read data at the last
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= mef_pkg::MEF_HSIZE_WORD;
		@(posedge mclk);
		while (!hreadyout) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (!hreadyout) @(posedge mclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, e);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 10; i++) begin
			rd_chk(8'(i * 4), 32'h0000_0000);
		end
	endtask
	task automatic t_link();
		wr(mef_pkg::MEF_OFS_SEL_BASE, 32'h0000_0043);
		wr(mef_pkg::MEF_OFS_SEL_BASE + mef_pkg::MEF_SEL_STRIDE, 32'h0000_0005);
		phy.status_read(5'h03, 1'b1, 1'b1);
		#1;
		check(link_state, 32'h0000_0008);
		check({31'h0, link_irq}, 32'h0000_0001);
		phy.status_read(5'h05, 1'b1, 1'b1);
		rd_chk(mef_pkg::MEF_OFS_LINK_RAW, 32'h0000_0003);
		rd_chk(mef_pkg::MEF_OFS_LINK_MASKED, 32'h0000_0001);
		phy.status_read(5'h03, 1'b0, 1'b1);
		#1;
		check(link_state, 32'h0000_0020);
		wr(mef_pkg::MEF_OFS_LINK_MASKED, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_LINK_MASKED, 32'h0000_0001);
		wr(mef_pkg::MEF_OFS_LINK_MASKED, 32'h0000_0001);
		rd_chk(mef_pkg::MEF_OFS_LINK_MASKED, 32'h0000_0000);
		check({31'h0, link_irq}, 32'h0000_0000);
		wr(mef_pkg::MEF_OFS_LINK_RAW, 32'h0000_0002);
		rd_chk(mef_pkg::MEF_OFS_LINK_RAW, 32'h0000_0001);
	endtask
	task automatic t_cmd();
		phy.finish(1);
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0002);
		check({30'h0, cmd_irq, irq}, 32'h0000_0000);
		wr(mef_pkg::MEF_OFS_CMD_MASK_SET, 32'h0000_0002);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASKED, 32'h0000_0002);
		check({30'h0, cmd_irq, irq}, 32'h0000_0003);
		phy.finish(0);
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0003);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASKED, 32'h0000_0002);
		wr(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0003);
		wr(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0002);
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0001);
		check({30'h0, cmd_irq, irq}, 32'h0000_0000);
	endtask
	task automatic t_clear();
		wr(mef_pkg::MEF_OFS_CMD_MASK_SET, 32'h0000_0001);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASKED, 32'h0000_0001);
		check({30'h0, cmd_irq, irq}, 32'h0000_0003);
		// completion lands on the very edge that applies the clear: set wins
		fork
			wr(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0001);
			begin
				@(posedge mclk);
				phy.finish(0);
			end
		join
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0001);
		wr(mef_pkg::MEF_OFS_CMD_MASKED, 32'h0000_0001);
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0000);
		check({30'h0, cmd_irq, irq}, 32'h0000_0000);
		phy.finish(0);
		wr(mef_pkg::MEF_OFS_CMD_MASK_CLR, 32'h0000_0003);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASK_SET, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASKED, 32'h0000_0000);
		check({30'h0, cmd_irq, irq}, 32'h0000_0000);
	endtask
	task automatic t_rst_mid();
		wr(mef_pkg::MEF_OFS_CMD_MASK_SET, 32'h0000_0002);
		phy.finish(1);
		rd_chk(mef_pkg::MEF_OFS_LINK_STATE, 32'h0000_0020);
		wr(mef_pkg::MEF_OFS_SEL_BASE + mef_pkg::MEF_SEL_STRIDE, 32'h0000_00ff);
		rd_chk(mef_pkg::MEF_OFS_SEL_BASE + mef_pkg::MEF_SEL_STRIDE, 32'h0000_005f);
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd_chk(mef_pkg::MEF_OFS_CMD_RAW, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_CMD_MASK_SET, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_SEL_BASE + mef_pkg::MEF_SEL_STRIDE, 32'h0000_0000);
		rd_chk(mef_pkg::MEF_OFS_LINK_STATE, 32'h0000_0000);
		check({29'h0, link_irq, cmd_irq, irq}, 32'h0000_0000);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_link();
		t_cmd();
		t_clear();
		t_rst_mid();
		print_verdict();
	end
endmodule
bind mef_top mef_props #(.NCH(NCH)) u_props (.mclk, .resetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .status_rd_done, .status_rd_phy, .status_rd_ack,
	.status_rd_link, .cmd_done, .link_state, .link_irq, .cmd_irq, .irq);
`default_nettype wire
